// ---- hdl/eeprom_access_control.sv ----
// control of the on-chip data memory: address, data and control registers
// assumes the core drives io_* synchronously on clk, one access per cycle,
// and that por_n falls only at power-up while arst_n is the system reset
// Function
// - control bits 7 and 6 always read as zero.
// - mode 00 erase+write 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved.
// - mode writes are ignored while the busy bit is set.
// - reset clears mode to 00 unless programming is in progress.
// - ready interrupt passes only when enable and core interrupt flag are set.
// - ready interrupt is a level held while memory is not busy.
// - programming starts only if busy bit set within four cycles of master enable.
// - setting busy bit with master enable clear starts nothing.
// - hardware clears master enable four cycles after software sets it, or when a program starts.
// - busy bit stays set for the mode's time, then hardware clears it.
// - starting a program stalls the core for two cycles.
// - read strobe loads the addressed byte into the data register at once.
// - each read strobe taken while idle stalls the core for four cycles.
// - during a write, reads and address changes are refused.
// - reset clears ready enable, master enable and read strobe bits.
// - data register feeds writes and receives read bytes.
// - address is a low byte plus one high bit; unused bits read zero.
// - a write in progress survives a system reset.
module eeprom_access_control
#(
   parameter int ATOMIC_CYC = nvm_pkg::ATOMIC_CYCLES,
   parameter int SPLIT_CYC  = nvm_pkg::SPLIT_CYCLES
)
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       por_n,
   input  wire logic [5:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   input  wire logic       global_irq_enable,
   output logic            ready_irq,
   output logic            cpu_halt
);
   import nvm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]        mem [MEM_DEPTH];

   logic              rie_reg, rie_next;
   logic              mpe_reg, mpe_next;
   logic [2:0]        mpe_cnt_reg, mpe_cnt_next;
   logic [2:0]        stall_reg, stall_next;
   logic [7:0]        data_reg, data_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [7:0]        rdata_reg, rdata_next;
   logic              rst_hold_reg;

   eng_state_t        state_reg, state_next;
   prog_mode_t        mode_reg, mode_next;
   prog_mode_t        op_mode_reg, op_mode_next;
   logic [ADDR_W-1:0] op_addr_reg, op_addr_next;
   logic [7:0]        op_data_reg, op_data_next;

   logic              ctrl_wr;
   logic              busy;
   logic              start;
   logic              read_go;
   prog_mode_t        wr_mode;
   logic              tmr_running;
   logic              tmr_expired;
   logic [CNT_W-1:0]  tmr_load_value;
   logic [7:0]        commit_byte;

   assign ctrl_wr = io_wr && (io_addr == OFF_CONTROL);
   assign busy    = (state_reg != ST_IDLE);
   assign wr_mode = prog_mode_t'(io_wdata[BIT_MODE_HI:BIT_MODE_LO]);

   // program only when armed and idle; reserved mode is never started
   assign start = ctrl_wr && io_wdata[BIT_PROG_ENABLE] && mpe_reg && !busy
                  && (wr_mode != MODE_RESERVED);
   assign read_go = ctrl_wr && io_wdata[BIT_READ_STROBE] && !busy && !start;

   ////////////////////////////////////////////////////////////////////////
   // software-visible control state (system reset)

   always_comb
   begin
      rie_next     = rie_reg;
      mpe_next     = mpe_reg;
      mpe_cnt_next = mpe_cnt_reg;
      stall_next   = (stall_reg != 3'd0) ? stall_reg - 3'd1 : 3'd0;
      data_next    = data_reg;
      addr_next    = addr_reg;
      rdata_next   = rdata_reg;

      if (mpe_cnt_reg != 3'd0)
      begin
         mpe_cnt_next = mpe_cnt_reg - 3'd1;
         if (mpe_cnt_reg == 3'd1)
            mpe_next = 1'b0;
      end

      if (ctrl_wr)
      begin
         rie_next = io_wdata[BIT_READY_IRQ_EN];
         if (start)
         begin
            // arming is spent by the program it enabled
            mpe_next     = 1'b0;
            mpe_cnt_next = 3'd0;
         end
         else if (io_wdata[BIT_MASTER_ENABLE] && !mpe_reg)
         begin
            mpe_next     = 1'b1;
            mpe_cnt_next = MASTER_WINDOW;
         end
      end

      if (start)
      begin
         stall_next = STALL_PROG;
      end
      else if (read_go)
      begin
         stall_next = STALL_READ;
         data_next  = mem[addr_reg];
      end

      if (io_wr && (io_addr == OFF_DATA))
         data_next = io_wdata;
      // address is frozen while a write is running
      if (io_wr && !busy && (io_addr == OFF_ADDR_LO))
         addr_next[7:0] = io_wdata;
      if (io_wr && !busy && (io_addr == OFF_ADDR_HI))
         addr_next[8] = io_wdata[0];

      if (io_rd)
      begin
         case (io_addr)
            OFF_CONTROL: rdata_next = {2'b00, mode_reg, rie_reg,
                                       mpe_reg, busy, 1'b0};
            OFF_DATA:    rdata_next = data_reg;
            OFF_ADDR_LO: rdata_next = addr_reg[7:0];
            OFF_ADDR_HI: rdata_next = {7'b000_0000, addr_reg[8]};
            default:     rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rie_reg      <= 1'b0;
         mpe_reg      <= 1'b0;
         mpe_cnt_reg  <= 3'd0;
         stall_reg    <= 3'd0;
         data_reg     <= DATA_RESET;
         addr_reg     <= ADDR_RESET;
         rdata_reg    <= 8'h00;
         rst_hold_reg <= 1'b1;
      end
      else
      begin
         rie_reg      <= rie_next;
         mpe_reg      <= mpe_next;
         mpe_cnt_reg  <= mpe_cnt_next;
         stall_reg    <= stall_next;
         data_reg     <= data_next;
         addr_reg     <= addr_next;
         rdata_reg    <= rdata_next;
         rst_hold_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // programming engine (power-on reset only)

   always_comb
   begin
      tmr_load_value = (wr_mode == MODE_ATOMIC) ? CNT_W'(ATOMIC_CYC)
                                                : CNT_W'(SPLIT_CYC);
   end

   prog_timer u_timer
   (
      .clk        (clk),
      .por_n      (por_n),
      .load       (start),
      .load_value (tmr_load_value),
      .running    (tmr_running),
      .expired    (tmr_expired)
   );

   always_comb
   begin
      state_next   = state_reg;
      mode_next    = mode_reg;
      op_mode_next = op_mode_reg;
      op_addr_next = op_addr_reg;
      op_data_next = op_data_reg;
      // the mode field follows the system reset only when idle
      if (rst_hold_reg && !busy)
         mode_next = MODE_RESET;
      else if (ctrl_wr && !busy)
         mode_next = wr_mode;
      case (state_reg)
         ST_IDLE:
         begin
            if (start)
            begin
               state_next   = ST_PROG;
               op_mode_next = wr_mode;
               op_addr_next = addr_reg;
               op_data_next = data_reg;
            end
         end
         ST_PROG:
         begin
            if (tmr_expired)
               state_next = ST_COMMIT;
         end
         ST_COMMIT: state_next = ST_IDLE;
         default:   state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge por_n)
   begin
      if (!por_n)
      begin
         state_reg   <= ST_IDLE;
         mode_reg    <= MODE_RESET;
         op_mode_reg <= MODE_RESET;
         op_addr_reg <= ADDR_RESET;
         op_data_reg <= DATA_RESET;
      end
      else
      begin
         state_reg   <= state_next;
         mode_reg    <= mode_next;
         op_mode_reg <= op_mode_next;
         op_addr_reg <= op_addr_next;
         op_data_reg <= op_data_next;
      end
   end

   // a write without erase can only clear bits
   always_comb
   begin
      case (op_mode_reg)
         MODE_ERASE: commit_byte = ERASED_BYTE;
         MODE_WRITE: commit_byte = mem[op_addr_reg] & op_data_reg;
         default:    commit_byte = op_data_reg;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (state_reg == ST_COMMIT)
         mem[op_addr_reg] <= commit_byte;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign io_rdata  = rdata_reg;
   assign ready_irq = rie_reg && global_irq_enable && !busy;
   assign cpu_halt  = (stall_reg != 3'd0);

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n || !por_n);

   sequence s_prog_stall;
      cpu_halt ##1 cpu_halt ##1 !cpu_halt;
   endsequence

   sequence s_read_stall;
      cpu_halt [*4] ##1 !cpu_halt;
   endsequence

   a_reserved_read_zero: assert property (
      io_rd && io_addr == OFF_CONTROL |=> io_rdata[7:6] == 2'b00)
      else $error("reserved control bits read nonzero");

   a_mode_frozen_busy: assert property (
      busy && ctrl_wr |=> $stable(mode_reg))
      else $error("mode changed while busy");

   a_mode_reset_idle: assert property (
      rst_hold_reg && !busy |=> mode_reg == MODE_RESET)
      else $error("mode not cleared by reset while idle");

   a_irq_busy_low: assert property (
      tmr_running |-> !ready_irq)
      else $error("ready interrupt raised while programming");

   a_unarmed_no_start: assert property (
      ctrl_wr && io_wdata[BIT_PROG_ENABLE] && !mpe_reg && !busy |=> !busy)
      else $error("program started without master enable");

   a_master_self_clear: assert property (
      $rose(mpe_reg) |-> ##4 !mpe_reg)
      else $error("master enable not cleared after four cycles");

   a_busy_holds: assert property (
      start |=> busy [*8])
      else $error("busy bit dropped early");

   a_prog_stall_two: assert property (
      start |=> s_prog_stall)
      else $error("program stall is not two cycles");

   a_read_stall_four: assert property (
      read_go |=> s_read_stall)
      else $error("read stall is not four cycles");

   a_read_loads_data: assert property (
      read_go && !(io_wr && io_addr == OFF_DATA) |=> data_reg == mem[$past(addr_reg)])
      else $error("read strobe did not load data register");

   a_addr_frozen_busy: assert property (
      busy |=> $stable(addr_reg))
      else $error("address changed during write");

   a_reset_clears_bits: assert property (
      rst_hold_reg |-> !rie_reg && !mpe_reg)
      else $error("control bits not cleared by reset");

endmodule

// ---- hdl/nvm_pkg.sv ----
// constants and types shared by the data-memory access control logic
// assumes a 25 MHz system clock and a 6-bit I/O register address space
package nvm_pkg;

   // I/O register offsets
   localparam logic [5:0] OFF_CONTROL  = 6'h1C;
   localparam logic [5:0] OFF_DATA     = 6'h1D;
   localparam logic [5:0] OFF_ADDR_LO  = 6'h1E;
   localparam logic [5:0] OFF_ADDR_HI  = 6'h1F;

   // control register bit positions
   localparam int BIT_READ_STROBE   = 0;
   localparam int BIT_PROG_ENABLE   = 1;
   localparam int BIT_MASTER_ENABLE = 2;
   localparam int BIT_READY_IRQ_EN  = 3;
   localparam int BIT_MODE_LO       = 4;
   localparam int BIT_MODE_HI       = 5;

   // geometry
   localparam int ADDR_W = 9;
   localparam int MEM_DEPTH = 512;
   localparam int CNT_W = 17;

   // values after reset, and the value of an erased byte
   localparam logic [7:0]        DATA_RESET   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET   = 9'h000;
   localparam logic [7:0]        ERASED_BYTE  = 8'hFF;

   // programming modes
   typedef enum logic [1:0] {
      MODE_ATOMIC     = 2'b00,
      MODE_ERASE      = 2'b01,
      MODE_WRITE      = 2'b10,
      MODE_RESERVED   = 2'b11
   } prog_mode_t;
   localparam prog_mode_t MODE_RESET = MODE_ATOMIC;

   // engine states, gray along idle -> program -> commit
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_PROG   = 2'b01,
      ST_COMMIT = 2'b11
   } eng_state_t;

   // timing
   localparam int CLK_PERIOD_NS     = 40;
   localparam int ATOMIC_TIME_NS    = 3_400_000;
   localparam int SPLIT_TIME_NS     = 1_800_000;
   localparam int ATOMIC_CYCLES     = ATOMIC_TIME_NS / CLK_PERIOD_NS;
   localparam int SPLIT_CYCLES      = SPLIT_TIME_NS / CLK_PERIOD_NS;
   localparam logic [2:0] MASTER_WINDOW = 3'd4;
   localparam logic [2:0] STALL_PROG    = 3'd2;
   localparam logic [2:0] STALL_READ    = 3'd4;

endpackage

// ---- hdl/prog_timer.sv ----
// down-counter that times one programming operation
// assumes load is a one-cycle pulse and is only given while idle
module prog_timer
(
   input  wire logic                      clk,
   input  wire logic                      por_n,
   input  wire logic                      load,
   input  wire logic [nvm_pkg::CNT_W-1:0] load_value,
   output logic                           running,
   output logic                           expired
);
   import nvm_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic             expired_reg;
   logic             expired_next;

   always_comb
   begin
      count_next   = count_reg;
      expired_next = 1'b0;
      if (load)
      begin
         count_next = load_value;
      end
      else if (count_reg != '0)
      begin
         count_next   = count_reg - 1'b1;
         expired_next = (count_reg == CNT_W'(1));
      end
   end

   // powered-up reset only: a system reset must not cut a write short
   always_ff @(posedge clk or negedge por_n)
   begin
      if (!por_n)
      begin
         count_reg   <= '0;
         expired_reg <= 1'b0;
      end
      else
      begin
         count_reg   <= count_next;
         expired_reg <= expired_next;
      end
   end

   assign running = (count_reg != '0);
   assign expired = expired_reg;

endmodule

// ---- test/eeprom_access_control_test.sv ----
// self-checking bench for the data-memory access control block
// assumes the shortened programming counts set below and one access per cycle
module eeprom_access_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   import nvm_pkg::*;

   localparam int T_AT = 60;
   localparam int T_SP = 30;

   logic       clk;
   logic       arst_n;
   logic       por_n;
   logic [5:0] io_addr;
   logic       io_wr;
   logic       io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic       global_irq_enable;
   logic       ready_irq;
   logic       cpu_halt;
   int         n_errors;
   int         cmp_count;

   eeprom_access_control #(.ATOMIC_CYC(T_AT), .SPLIT_CYC(T_SP)) dut
   (
      .clk               (clk),
      .arst_n            (arst_n),
      .por_n             (por_n),
      .io_addr           (io_addr),
      .io_wr             (io_wr),
      .io_rd             (io_rd),
      .io_wdata          (io_wdata),
      .io_rdata          (io_rdata),
      .global_irq_enable (global_irq_enable),
      .ready_irq         (ready_irq),
      .cpu_halt          (cpu_halt)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // strobes are dropped 1 ns after the taking edge, so calls never collide
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge clk);
      #1 io_wr = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 io_addr = a;
      io_rd = 1'b1;
      @(posedge clk);
      #1 io_rd = 1'b0;
      d = io_rdata;
   endtask

   // stall cycles seen in the 8 cycles after the last write
   task automatic halts(output logic [7:0] n);
      n = 8'h00;
      repeat (8)
      begin
         @(negedge clk);
         if (cpu_halt === 1'b1)
            n++;
      end
   endtask

   task automatic wait_idle();
      logic [7:0] d;
      for (int i = 0; i < 60; i++)
      begin
         rd(OFF_CONTROL, d);
         if (d[BIT_PROG_ENABLE] === 1'b0)
            return;
      end
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, d, 8'h00);
      end_of_test();
   endtask

   task automatic pulse_reset();
      @(posedge clk);
      #1 arst_n = 1'b0;
      @(posedge clk);
      #1 arst_n = 1'b1;
   endtask

   task automatic start(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
      wr(OFF_ADDR_LO, a[7:0]);
      wr(OFF_ADDR_HI, {7'h00, a[8]});
      wr(OFF_DATA, d);
      wr(OFF_CONTROL, {2'b00, m, 4'b0100});
      wr(OFF_CONTROL, {2'b00, m, 4'b0010});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] d;
      rd(OFF_CONTROL, d);
      check8(d, 8'h00);
      rd(OFF_DATA, d);
      check8(d, DATA_RESET);
      rd(6'h15, d);
      check8(d, 8'h00);
      $display("reset values done");
   endtask

   task automatic t_irq();
      logic [7:0] d;
      wr(OFF_CONTROL, 8'h48);
      rd(OFF_CONTROL, d);
      check8(d, 8'h08);
      @(negedge clk);
      check8({7'h00, ready_irq}, 8'h00);
      @(posedge clk);
      #1 global_irq_enable = 1'b1;
      @(negedge clk);
      check8({7'h00, ready_irq}, 8'h01);
      wr(OFF_CONTROL, 8'h00);
      @(negedge clk);
      check8({7'h00, ready_irq}, 8'h00);
      $display("ready request done");
   endtask

   task automatic t_arm();
      logic [7:0] d;
      wr(OFF_CONTROL, 8'h04);
      rd(OFF_CONTROL, d);
      check8(d, 8'h04);
      repeat (4) @(posedge clk);
      rd(OFF_CONTROL, d);
      check8(d, 8'h00);
      wr(OFF_CONTROL, 8'h02);
      halts(d);
      check8(d, 8'h00);
      rd(OFF_CONTROL, d);
      check8(d, 8'h00);
      wr(OFF_CONTROL, 8'h04);
      wr(OFF_CONTROL, 8'h32);
      halts(d);
      check8(d, 8'h00);
      rd(OFF_CONTROL, d);
      check8(d & 8'h02, 8'h00);
      $display("arming done");
   endtask

   // a mode write, an address write and a read strobe all land while busy
   task automatic t_prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                         input int t, input logic [7:0] exp);
      logic [7:0] r;
      start(m, a, d);
      halts(r);
      check8(r, 8'h02);
      rd(OFF_CONTROL, r);
      check8(r, {2'b00, m, 4'b0010});
      wr(OFF_CONTROL, {2'b00, m ^ 2'b11, 4'b1010});
      rd(OFF_CONTROL, r);
      check8(r, {2'b00, m, 4'b1010});
      check8({7'h00, ready_irq}, 8'h00);
      wr(OFF_ADDR_LO, ~a[7:0]);
      wr(OFF_CONTROL, {2'b00, m, 4'b1011});
      halts(r);
      check8(r, 8'h00);
      repeat (t - 30) @(posedge clk);
      rd(OFF_CONTROL, r);
      check8(r & 8'h02, 8'h02);
      wait_idle();
      @(negedge clk);
      check8({7'h00, ready_irq}, 8'h01);
      rd(OFF_ADDR_LO, r);
      check8(r, a[7:0]);
      rd(OFF_ADDR_HI, r);
      check8(r, {7'h00, a[8]});
      wr(OFF_CONTROL, 8'h01);
      halts(r);
      check8(r, 8'h04);
      rd(OFF_DATA, r);
      check8(r, exp);
      $display("program mode %b done", m);
   endtask

   task automatic t_reset_mid();
      logic [7:0] r;
      start(MODE_ERASE, 9'h010, 8'h00);
      wr(OFF_CONTROL, 8'h1A);
      pulse_reset();
      rd(OFF_CONTROL, r);
      check8(r, 8'h12);
      wait_idle();
      rd(OFF_CONTROL, r);
      check8(r, 8'h10);
      pulse_reset();
      rd(OFF_CONTROL, r);
      check8(r, 8'h00);
      wr(OFF_ADDR_LO, 8'h10);
      wr(OFF_ADDR_HI, 8'h00);
      wr(OFF_CONTROL, 8'h01);
      rd(OFF_DATA, r);
      check8(r, ERASED_BYTE);
      $display("reset during program done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      n_errors = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      por_n = 1'b0;
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      global_irq_enable = 1'b0;
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      por_n = 1'b1;
      t_reset();
      t_irq();
      t_arm();
      t_prog(MODE_ATOMIC, 9'h105, 8'hA5, T_AT, 8'hA5);
      t_prog(MODE_ERASE, 9'h105, 8'h00, T_SP, 8'hFF);
      t_prog(MODE_WRITE, 9'h105, 8'h3C, T_SP, 8'h3C);
      t_prog(MODE_WRITE, 9'h105, 8'hF0, T_SP, 8'h30);
      t_reset_mid();
      end_of_test();
   end
endmodule
